// file: inc/uavi_pkg.sv
/*
 * Constants for the USB/FIFO autovector interrupt block: entry and
 * vector addresses, vector tables, source counts and power states.
 * Assumes it is compiled before every design file that names it.
 */
package uavi_pkg;

	// -----------------------------------------------------------------
	// Source counts and index widths
	// -----------------------------------------------------------------
	localparam int unsigned USB_SRC_N  = 27;          // USB line sources
	localparam int unsigned FIFO_SRC_N = 14;          // FIFO line sources
	localparam int unsigned USB_IDX_W  = 5;           // Index width, USB
	localparam int unsigned FIFO_IDX_W = 4;           // Index width, FIFO

	// -----------------------------------------------------------------
	// Code addresses seen by the core
	// -----------------------------------------------------------------
	localparam logic [15:0] USB_ENTRY_ADDR = 16'h0043;  // USB line entry
	localparam logic [15:0] USB_VEC_ADDR   = 16'h0045;  // USB low target byte
	localparam logic [15:0] FIFO_ENTRY_ADDR = 16'h0053; // FIFO line entry
	localparam logic [15:0] FIFO_PAGE_ADDR = 16'h0054;  // Page byte, software
	localparam logic [15:0] FIFO_VEC_ADDR  = 16'h0055;  // FIFO low target byte

	// -----------------------------------------------------------------
	// Vector bytes, index 0 is highest priority
	// -----------------------------------------------------------------
	// Gaps 14, 1c, 44, 68, 6c own no source; bit 26 is the spare slot
	localparam logic [USB_SRC_N-1:0][7:0] USB_VEC_TBL = {
		8'h64, 8'h7c, 8'h78, 8'h74, 8'h70, 8'h60, 8'h5c, 8'h58, 8'h54,
		8'h50, 8'h4c, 8'h48, 8'h40, 8'h3c, 8'h38, 8'h34, 8'h30, 8'h2c,
		8'h28, 8'h24, 8'h20, 8'h18, 8'h10, 8'h0c, 8'h08, 8'h04, 8'h00};
	localparam logic [7:0] FIFO_VEC_BASE = 8'h80;     // Level flag, ep 2
	localparam logic [7:0] VEC_RST       = 8'h00;     // Vector after reset

	// -----------------------------------------------------------------
	// Power controller states
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		UAVI_PWR_RUN  = 2'b00,                        // Clocks running
		UAVI_PWR_DOWN = 2'b01,                        // Oscillator stopped
		UAVI_PWR_LOCK = 2'b10                         // Waiting for PLL
	} uavi_pwr_t;

endpackage : uavi_pkg

// file: hdl/uavi_prio_enc.sv
/*
 * Fixed priority encoder: lowest set request index wins.
 * Assumes the caller registers the result; purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none

module uavi_prio_enc #(
	parameter int unsigned N     = 8,   // Number of requests
	parameter int unsigned IDX_W = 3    // Index width
) (
	input  wire logic [N-1:0]     i_req,
	output logic                  o_any,
	output logic [IDX_W-1:0]      o_idx
);

	// -----------------------------------------------------------------
	// Scan from the top down so the lowest index stands last
	// -----------------------------------------------------------------
	always_comb begin
		o_any = |i_req;
		o_idx = '0;
		for (int k = N - 1; k >= 0; k--) begin
			if (i_req[k]) begin           // Lower index overrides
				o_idx = IDX_W'(k);
			end
		end
	end

endmodule : uavi_prio_enc

`default_nettype wire

// file: hdl/uavi_pwr_ctl.sv
/*
 * Power-down entry and wakeup sequencing: stops oscillator and PLL,
 * restarts them on a wakeup source, pulses the wakeup interrupt.
 * Assumes the pins and PLL lock come from outside the clock domain.
 */
`timescale 1ns/100ps
`default_nettype none

module uavi_pwr_ctl (
	input  wire logic i_clk_sys,
	input  wire logic i_rst_n,
	input  wire logic i_power_down_bit,        // Core set power bit, pulse
	input  wire logic i_bus_activity,          // Bus activity, async
	input  wire logic i_wakeup_pin,            // Primary wakeup pin, async
	input  wire logic i_wakeup_active_high,    // 0: primary active low
	input  wire logic i_secondary_wakeup_pin,  // Secondary pin, async
	input  wire logic i_secondary_is_gpio,     // 1: secondary is plain I/O
	input  wire logic i_pll_locked,            // PLL lock, async
	output logic      o_power_down,            // Chip in power-down
	output logic      o_osc_enable,            // Oscillator run
	output logic      o_pll_enable,            // PLL run
	output logic      o_wakeup_irq             // Wakeup interrupt, pulse
);

	// -----------------------------------------------------------------
	// Two-stage synchronisers for the async inputs
	// -----------------------------------------------------------------
	logic [3:0]          sync1_ff;             // First stage only
	logic [3:0]          sync2_ff;             // Safe to read
	uavi_pkg::uavi_pwr_t state_ff;             // Power state
	uavi_pkg::uavi_pwr_t nxt_state;
	logic                irq_ff;               // Wakeup pulse
	logic                nxt_irq;
	logic                osc_ff;               // Oscillator enable
	logic                nxt_osc;
	logic                wake_any;             // Any wakeup source

	// Raw pins into the first stage, nothing else reads it
	// Primary pin resets to its idle high level, so an early power-down
	// right after reset is not taken for a wakeup
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_ff <= 4'h2;
			sync2_ff <= 4'h2;
		end else begin
			sync1_ff <= {i_pll_locked, i_secondary_wakeup_pin, i_wakeup_pin,
				i_bus_activity};
			sync2_ff <= sync1_ff;
		end
	end

	// -----------------------------------------------------------------
	// Wakeup source merge
	// -----------------------------------------------------------------
	always_comb begin
		wake_any = sync2_ff[0]
			| (sync2_ff[1] ~^ i_wakeup_active_high)
			| (sync2_ff[2] & ~i_secondary_is_gpio);
	end

	// -----------------------------------------------------------------
	// Power sequencer, next state
	// -----------------------------------------------------------------
	// The core clock stops in power-down in silicon; this logic is
	// meant to sit on the always-on edge of that clock tree.
	always_comb begin
		nxt_state = state_ff;
		nxt_irq   = 1'b0;
		nxt_osc   = osc_ff;
		unique case (state_ff)
			uavi_pkg::UAVI_PWR_RUN: begin
				if (i_power_down_bit) begin
					nxt_state = uavi_pkg::UAVI_PWR_DOWN;
					nxt_osc   = 1'b0;
				end
			end
			uavi_pkg::UAVI_PWR_DOWN: begin
				if (wake_any) begin
					nxt_state = uavi_pkg::UAVI_PWR_LOCK;
					nxt_osc   = 1'b1;
				end
			end
			uavi_pkg::UAVI_PWR_LOCK: begin
				if (sync2_ff[3]) begin
					nxt_state = uavi_pkg::UAVI_PWR_RUN;
					nxt_irq   = 1'b1;
				end
			end
			default: begin                               // Illegal code
				nxt_state = uavi_pkg::UAVI_PWR_RUN;
				nxt_osc   = 1'b1;
			end
		endcase
	end

	// Register the sequencer
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff <= uavi_pkg::UAVI_PWR_RUN;
			irq_ff   <= 1'b0;
			osc_ff   <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			irq_ff   <= nxt_irq;
			osc_ff   <= nxt_osc;
		end
	end

	assign o_power_down = (state_ff == uavi_pkg::UAVI_PWR_DOWN);
	assign o_osc_enable = osc_ff;
	assign o_pll_enable = osc_ff;             // PLL follows the oscillator
	assign o_wakeup_irq = irq_ff;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	sequence s_wake_seen;
		o_power_down && wake_any;
	endsequence
	sequence s_locked_run;
		(state_ff == uavi_pkg::UAVI_PWR_LOCK) && sync2_ff[3];
	endsequence

	pd_enter_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_ff == uavi_pkg::UAVI_PWR_RUN) && i_power_down_bit
		|=> o_power_down && !o_osc_enable && !o_pll_enable)
		else $error("power-down not entered");
	wake_osc_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		s_wake_seen |=> o_osc_enable && !o_wakeup_irq
			&& (state_ff == uavi_pkg::UAVI_PWR_LOCK))
		else $error("oscillator not restarted on wakeup");
	wake_irq_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_wakeup_irq |-> $past(state_ff) == uavi_pkg::UAVI_PWR_LOCK
			&& $past(sync2_ff[3]))
		else $error("wakeup irq before PLL lock");
	lock_run_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		s_locked_run |=> o_wakeup_irq && !o_power_down && o_osc_enable)
		else $error("no wakeup irq after PLL lock");

endmodule : uavi_pwr_ctl

`default_nettype wire

// file: hdl/uavi_top.sv
/*
 * Second-level interrupt vectoring for the USB and FIFO shared lines,
 * jump-byte substitution on code fetch, and power-down with wakeup.
 * Assumes the core pulses the set/clear inputs on its own clock and
 * fetches code through this block; pins arrive asynchronously.
 */
`timescale 1ns/100ps
`default_nettype none

module uavi_top #(
	parameter int unsigned USB_N  = uavi_pkg::USB_SRC_N,   // USB sources
	parameter int unsigned FIFO_N = uavi_pkg::FIFO_SRC_N   // FIFO sources
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst_n,
	// Source events and enables
	input  wire logic [USB_N-1:0]  i_usb_evt_set,          // Event pulses
	input  wire logic [USB_N-1:0]  i_usb_evt_clr,          // Core clears
	input  wire logic [USB_N-1:0]  i_usb_evt_en,           // Per-source enable
	input  wire logic [FIFO_N-1:0] i_fifo_evt_set,
	input  wire logic [FIFO_N-1:0] i_fifo_evt_clr,
	input  wire logic [FIFO_N-1:0] i_fifo_evt_en,
	// Setup bits
	input  wire logic              i_usb_autovector_enable,
	input  wire logic              i_fifo_autovector_enable,
	// Code fetch path
	input  wire logic              i_fetch_req,            // Fetch pulse
	input  wire logic [15:0]       i_fetch_addr,           // Code address
	input  wire logic [7:0]        i_fetch_byte,           // Memory byte
	output logic                   o_fetch_vld,            // Data valid
	output logic [7:0]             o_fetch_data,           // Byte to core
	// Interrupt lines to the core
	output logic                   o_usb_shared_irq,
	output logic                   o_fifo_shared_irq,
	output logic [7:0]             o_usb_vector_byte,
	output logic [7:0]             o_fifo_vector_byte,
	output logic [15:0]            o_entry_addr,           // Vector address
	output logic [USB_N-1:0]       o_usb_pending,          // Sticky flags
	output logic [FIFO_N-1:0]      o_fifo_pending,
	// Power
	input  wire logic              i_power_down_bit,
	input  wire logic              i_bus_activity,
	input  wire logic              i_wakeup_pin,
	input  wire logic              i_wakeup_active_high,
	input  wire logic              i_secondary_wakeup_pin,
	input  wire logic              i_secondary_is_gpio,
	input  wire logic              i_pll_locked,
	output logic                   o_power_down,
	output logic                   o_osc_enable,
	output logic                   o_pll_enable,
	output logic                   o_wakeup_irq
);

	// -----------------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------------
	logic [USB_N-1:0]             usb_pend_ff;    // Sticky USB flags
	logic [USB_N-1:0]             nxt_usb_pend;
	logic [FIFO_N-1:0]            fifo_pend_ff;   // Sticky FIFO flags
	logic [FIFO_N-1:0]            nxt_fifo_pend;
	logic [USB_N-1:0]             usb_live;       // Pending and enabled
	logic [FIFO_N-1:0]            fifo_live;
	logic                         usb_any;        // Encoder results
	logic                         fifo_any;
	logic [uavi_pkg::USB_IDX_W-1:0]  usb_idx;
	logic [uavi_pkg::FIFO_IDX_W-1:0] fifo_idx;
	logic                         usb_irq_ff;     // Line outputs
	logic                         nxt_usb_irq;
	logic                         fifo_irq_ff;
	logic                         nxt_fifo_irq;
	logic [7:0]                   usb_vec_ff;     // Current vectors
	logic [7:0]                   nxt_usb_vec;
	logic [7:0]                   fifo_vec_ff;
	logic [7:0]                   nxt_fifo_vec;
	logic [15:0]                  entry_ff;       // Entry address
	logic [15:0]                  nxt_entry;
	logic                         fvld_ff;        // Fetch answer
	logic                         nxt_fvld;
	logic [7:0]                   fdata_ff;
	logic [7:0]                   nxt_fdata;

	// -----------------------------------------------------------------
	// Sticky source flags
	// -----------------------------------------------------------------
	// Set beats clear so an event landing on the clear is kept
	always_comb begin
		nxt_usb_pend  = (usb_pend_ff & ~i_usb_evt_clr) | i_usb_evt_set;
		nxt_fifo_pend = (fifo_pend_ff & ~i_fifo_evt_clr) | i_fifo_evt_set;
	end

	// Register the flags
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			usb_pend_ff  <= '0;
			fifo_pend_ff <= '0;
		end else begin
			usb_pend_ff  <= nxt_usb_pend;
			fifo_pend_ff <= nxt_fifo_pend;
		end
	end

	assign usb_live  = usb_pend_ff & i_usb_evt_en;
	assign fifo_live = fifo_pend_ff & i_fifo_evt_en;

	// -----------------------------------------------------------------
	// Priority resolution, lowest index first
	// -----------------------------------------------------------------
	uavi_prio_enc #(
		.N     (USB_N),
		.IDX_W (uavi_pkg::USB_IDX_W)
	) u_usb_enc (
		.i_req (usb_live),
		.o_any (usb_any),
		.o_idx (usb_idx)
	);

	uavi_prio_enc #(
		.N     (FIFO_N),
		.IDX_W (uavi_pkg::FIFO_IDX_W)
	) u_fifo_enc (
		.i_req (fifo_live),
		.o_any (fifo_any),
		.o_idx (fifo_idx)
	);

	// -----------------------------------------------------------------
	// Shared lines, vectors and entry address
	// -----------------------------------------------------------------
	// Vector holds its last value when nothing is pending, so a late
	// fetch after a clear still sees a defined byte
	always_comb begin
		nxt_usb_irq  = usb_any;
		nxt_fifo_irq = fifo_any;
		nxt_usb_vec  = usb_vec_ff;
		nxt_fifo_vec = fifo_vec_ff;
		if (usb_any) begin
			nxt_usb_vec = uavi_pkg::USB_VEC_TBL[usb_idx];
		end
		if (fifo_any) begin
			nxt_fifo_vec = uavi_pkg::FIFO_VEC_BASE
				+ {2'b00, fifo_idx, 2'b00};
		end
		// USB line outranks FIFO line, as in the core's native order
		if (usb_any) begin
			nxt_entry = uavi_pkg::USB_ENTRY_ADDR;
		end else begin
			nxt_entry = uavi_pkg::FIFO_ENTRY_ADDR;
		end
	end

	// Register line state
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			usb_irq_ff  <= 1'b0;
			fifo_irq_ff <= 1'b0;
			usb_vec_ff  <= uavi_pkg::VEC_RST;
			fifo_vec_ff <= uavi_pkg::VEC_RST;
			entry_ff    <= uavi_pkg::FIFO_ENTRY_ADDR;
		end else begin
			usb_irq_ff  <= nxt_usb_irq;
			fifo_irq_ff <= nxt_fifo_irq;
			usb_vec_ff  <= nxt_usb_vec;
			fifo_vec_ff <= nxt_fifo_vec;
			entry_ff    <= nxt_entry;
		end
	end

	// -----------------------------------------------------------------
	// Jump-byte substitution on code fetch
	// -----------------------------------------------------------------
	// Only the low target byte is replaced; the page byte before it
	// comes from code memory as software placed it
	always_comb begin
		nxt_fvld  = i_fetch_req;
		nxt_fdata = fdata_ff;
		if (i_fetch_req) begin
			nxt_fdata = i_fetch_byte;
			if (i_usb_autovector_enable
				&& (i_fetch_addr == uavi_pkg::USB_VEC_ADDR)) begin
				nxt_fdata = usb_vec_ff;
			end else if (i_fifo_autovector_enable
				&& (i_fetch_addr == uavi_pkg::FIFO_VEC_ADDR)) begin
				nxt_fdata = fifo_vec_ff;
			end
		end
	end

	// Register the fetch answer
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fvld_ff  <= 1'b0;
			fdata_ff <= 8'h00;
		end else begin
			fvld_ff  <= nxt_fvld;
			fdata_ff <= nxt_fdata;
		end
	end

	// -----------------------------------------------------------------
	// Power-down and wakeup
	// -----------------------------------------------------------------
	uavi_pwr_ctl u_pwr (
		.i_clk_sys              (i_clk_sys),
		.i_rst_n                (i_rst_n),
		.i_power_down_bit       (i_power_down_bit),
		.i_bus_activity         (i_bus_activity),
		.i_wakeup_pin           (i_wakeup_pin),
		.i_wakeup_active_high   (i_wakeup_active_high),
		.i_secondary_wakeup_pin (i_secondary_wakeup_pin),
		.i_secondary_is_gpio    (i_secondary_is_gpio),
		.i_pll_locked           (i_pll_locked),
		.o_power_down           (o_power_down),
		.o_osc_enable           (o_osc_enable),
		.o_pll_enable           (o_pll_enable),
		.o_wakeup_irq           (o_wakeup_irq)
	);

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign o_usb_shared_irq   = usb_irq_ff;
	assign o_fifo_shared_irq  = fifo_irq_ff;
	assign o_usb_vector_byte  = usb_vec_ff;
	assign o_fifo_vector_byte = fifo_vec_ff;
	assign o_entry_addr       = entry_ff;
	assign o_usb_pending      = usb_pend_ff;
	assign o_fifo_pending     = fifo_pend_ff;
	assign o_fetch_vld        = fvld_ff;
	assign o_fetch_data       = fdata_ff;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	usb_line_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_usb_shared_irq == $past(|(usb_pend_ff & i_usb_evt_en)))
		else $error("USB line does not follow pending sources");
	fifo_line_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_fifo_shared_irq == $past(|(fifo_pend_ff & i_fifo_evt_en)))
		else $error("FIFO line does not follow pending sources");
	set_wins_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_usb_evt_set[0] && i_usb_evt_clr[0]) |=> o_usb_pending[0])
		else $error("event lost on clear");
	usb_top_vec_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(usb_pend_ff[0] && i_usb_evt_en[0]) |=> o_usb_vector_byte == 8'h00)
		else $error("highest USB source not vectored to 00");
	usb_errlim_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(usb_live[20:0] == '0 && usb_live[21]) |=> o_usb_vector_byte == 8'h60)
		else $error("error limit vector wrong");
	fifo_vec_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(fifo_live[12:0] == '0 && fifo_live[13]) |=> o_fifo_vector_byte == 8'hb4)
		else $error("waveform event vector wrong");
	fifo_subst_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_fetch_req && i_fifo_autovector_enable && !i_usb_autovector_enable
			&& i_fetch_addr == 16'h0055)
		|=> o_fetch_vld && o_fetch_data == $past(o_fifo_vector_byte))
		else $error("FIFO vector not substituted");
	usb_subst_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_fetch_req && i_usb_autovector_enable && i_fetch_addr == 16'h0045)
		|=> o_fetch_data == $past(o_usb_vector_byte))
		else $error("USB vector not substituted");
	fetch_pass_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_fetch_req && i_fetch_addr != 16'h0045 && i_fetch_addr != 16'h0055)
		|=> o_fetch_data == $past(i_fetch_byte))
		else $error("page or code byte altered");
	entry_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(!usb_any && fifo_any) |=> o_entry_addr == 16'h0053)
		else $error("FIFO entry address wrong");

endmodule : uavi_top

`default_nettype wire

// file: bench/uavi_core_model.sv
/*
 * Core-side code memory model: passes each fetch on and answers
 * with the byte its own code memory holds at that address.
 * Assumes the bench raises i_go for one cycle per fetch.
 */
`timescale 1ns/100ps
`default_nettype none

module uavi_core_model #(
	parameter logic [7:0] PAGE = 8'h3a          // Jump-table page byte
) (
	input  wire logic        i_go,              // Fetch command
	input  wire logic [15:0] i_addr,            // Fetch address
	output logic             o_fetch_req,       // Fetch strobe
	output logic [15:0]      o_fetch_addr,      // Code address
	output logic [7:0]       o_fetch_byte       // Memory byte
);
	// Page byte preloaded by software; other bytes differ per address
	// so that a missed substitution never matches by accident
	always_comb begin
		o_fetch_req  = i_go;
		o_fetch_addr = i_addr;
		o_fetch_byte = (i_addr == 16'h0054) ? PAGE : (i_addr[7:0] ^ 8'h5a);
	end
endmodule : uavi_core_model
`default_nettype wire

// file: bench/test_usb_fifo_autovector_irq.sv
/*
 * Self-checking bench: vector priority, fetch substitution, power-down
 * and wakeup. Assumes the core model answers fetches from code memory.
 */
`timescale 1ns/100ps
`default_nettype none

module test_usb_fifo_autovector_irq;
	// Expected USB vectors, sources 0..25 in priority order
	localparam logic [7:0] UVEC [26] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h20,
		8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h48, 8'h4c, 8'h50,
		8'h54, 8'h58, 8'h5c, 8'h60, 8'h70, 8'h74, 8'h78, 8'h7c};
	logic        clk_sys = 1'b0;                           // 20 MHz clock
	logic        rst_n = 1'b0;                             // Reset, active low
	logic [26:0] usb_set, usb_clr, usb_en, upend;          // USB sources
	logic [13:0] fifo_set, fifo_clr, fifo_en, fpend;       // FIFO sources
	logic        usb_av, fifo_av, go, pwr, bus, wpin, wpin2, lock;
	logic        freq, fvld, uirq, firq, pd, osc, pll, wirq;
	logic        wah = 1'b0, gpio = 1'b0;                 // Wakeup pin config
	logic [15:0] addr, faddr, entry;
	logic [7:0]  fbyte, fdata, uvec, fvec;
	int          errors = 0;
	int          total_checks = 0;

	always #25 clk_sys = ~clk_sys;

	uavi_core_model uavi_core_model_i (.i_go(go), .i_addr(addr), .o_fetch_req(freq),
		.o_fetch_addr(faddr), .o_fetch_byte(fbyte));
	uavi_top uavi_top_i (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_usb_evt_set(usb_set),
		.i_usb_evt_clr(usb_clr), .i_usb_evt_en(usb_en), .i_fifo_evt_set(fifo_set),
		.i_fifo_evt_clr(fifo_clr), .i_fifo_evt_en(fifo_en), .i_usb_autovector_enable(usb_av),
		.i_fifo_autovector_enable(fifo_av), .i_fetch_req(freq), .i_fetch_addr(faddr),
		.i_fetch_byte(fbyte), .o_fetch_vld(fvld), .o_fetch_data(fdata),
		.o_usb_shared_irq(uirq), .o_fifo_shared_irq(firq), .o_usb_vector_byte(uvec),
		.o_fifo_vector_byte(fvec), .o_entry_addr(entry), .o_usb_pending(upend),
		.o_fifo_pending(fpend), .i_power_down_bit(pwr), .i_bus_activity(bus),
		.i_wakeup_pin(wpin), .i_wakeup_active_high(wah), .i_secondary_wakeup_pin(wpin2),
		.i_secondary_is_gpio(gpio), .i_pll_locked(lock), .o_power_down(pd),
		.o_osc_enable(osc), .o_pll_enable(pll), .o_wakeup_irq(wirq));

	// Compare and count; four-state compare so unknowns fail
	task automatic check(input string name, input logic [26:0] exp, input logic [26:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : check

	// Pulse set/clear bits for one cycle, then wait for vector update
	task automatic hit(input logic [26:0] us, uc, input logic [13:0] fs, fc);
		@(posedge clk_sys);
		{usb_set, usb_clr, fifo_set, fifo_clr} <= {us, uc, fs, fc};
		@(posedge clk_sys);
		{usb_set, usb_clr, fifo_set, fifo_clr} <= '0;
		@(posedge clk_sys);
		@(negedge clk_sys);
	endtask : hit

	// One code fetch; answer one cycle after the strobe is taken
	task automatic fetch(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		go   <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		go <= 1'b0;
		@(negedge clk_sys);
		check("fetch_vld", 1, fvld);
		check("fetch_data", exp, fdata);
		@(negedge clk_sys);
		check("fetch_vld_drop", 0, fvld);
	endtask : fetch

	// USB sources 0..25 at once, peeled off in priority order
	task automatic t_usb;
		hit(27'h3ffffff, '0, '0, '0);
		for (int k = 0; k < 26; k++) begin
			check("usb_irq", 1, uirq);
			check("usb_vector", UVEC[k], uvec);
			check("entry_addr", 16'h0043, entry);
			hit('0, 27'(1) << k, '0, '0);
		end
		check("usb_irq", 0, uirq);
		usb_en <= '0;
		hit(27'h1, 27'h1, '0, '0);
		check("usb_pending", 1, upend[0]);
		check("usb_irq", 0, uirq);
		usb_en <= '1;
		hit('0, 27'h1, '0, '0);
		$display("test usb vectors done");
	endtask : t_usb

	// Each FIFO source alone, then cleared
	task automatic t_fifo;
		for (int i = 0; i < 14; i++) begin
			hit('0, '0, 14'(1) << i, '0);
			check("fifo_irq", 1, firq);
			check("fifo_pending", 14'(1) << i, fpend);
			check("fifo_vector", 8'h80 + 8'(4 * i), fvec);
			check("entry_addr", 16'h0053, entry);
			hit('0, '0, '0, 14'(1) << i);
		end
		check("fifo_irq", 0, firq);
		$display("test fifo vectors done");
	endtask : t_fifo

	// Jump-byte substitution with autovector on and off
	task automatic t_fetch;
		hit(27'h10, '0, 14'h2000, '0);
		{usb_av, fifo_av} <= 2'b11;
		fetch(16'h0045, 8'h10);
		fetch(16'h0055, 8'hb4);
		fetch(16'h0054, 8'h3a);
		fetch(16'h0044, 8'h1e);
		{usb_av, fifo_av} <= 2'b00;
		fetch(16'h0045, 8'h1f);
		fetch(16'h0055, 8'h0f);
		hit('0, 27'h10, '0, 14'h2000);
		$display("test fetch substitution done");
	endtask : t_fetch

	// Power-down, then wake from each of the three sources
	task automatic t_power;
		for (int s = 0; s < 3; s++) begin
			@(posedge clk_sys);
			pwr  <= 1'b1;
			lock <= 1'b0;
			@(posedge clk_sys);
			pwr <= 1'b0;
			@(negedge clk_sys);
			check("power_down", 1, pd);
			check("osc_pll", 0, {osc, pll});
			@(posedge clk_sys);
			{bus, wpin, wpin2} <= {s == 0, s != 1, s == 2};
			repeat (6) @(posedge clk_sys);
			check("pll_enable", 1, pll);
			check("wakeup_irq", 0, wirq);
			lock <= 1'b1;
			for (int n = 0; n < 8 && wirq !== 1'b1; n++) @(negedge clk_sys);
			check("wakeup_irq", 1, wirq);
			check("power_down", 0, pd);
			{bus, wpin, wpin2} <= 3'b010;
		end
		$display("test power wakeup done");
	endtask : t_power

	// Secondary pin as plain I/O must not wake; primary pin set active high
	task automatic t_wake_cfg;
		@(posedge clk_sys);
		{pwr, lock, gpio} <= 3'b101;
		@(posedge clk_sys);
		pwr   <= 1'b0;
		wpin2 <= 1'b1;
		repeat (6) @(negedge clk_sys);
		check("gpio_no_wake", 1, pd);
		wah <= 1'b1;
		repeat (4) @(negedge clk_sys);
		check("active_high_wake", 1, osc);
		lock <= 1'b1;
		for (int n = 0; n < 8 && wirq !== 1'b1; n++) @(negedge clk_sys);
		check("wakeup_irq_cfg", 1, wirq);
		{wah, gpio, wpin2} <= 3'b000;
		$display("test wakeup pin config done");
	endtask : t_wake_cfg

	// Final summary and verdict
	task automatic conclude;
		$display("checks %0d, errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	// Watchdog: the whole run needs well under 3000 cycles
	initial begin
		#150000;
		errors++;
		conclude();
	end

	// Main sequence: quiet inputs, reset, reset values, then the tests
	initial begin
		{usb_set, usb_clr, fifo_set, fifo_clr, addr} = '0;
		{usb_en, fifo_en} = '1;
		{usb_av, fifo_av, go, pwr, bus, wpin2, lock} = '0;
		wpin = 1'b1;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(negedge clk_sys);
		check("reset_entry", 16'h0053, entry);
		check("reset_osc_pd", 2'b10, {osc, pd});
		t_usb();
		t_fifo();
		t_fetch();
		t_power();
		t_wake_cfg();
		conclude();
	end
endmodule : test_usb_fifo_autovector_irq
`default_nettype wire
